/* src/fm_demod_rds_control.sv */
/*
  APB register block for the FM demodulator and radio data decoder.
  Decodes control and tuning registers onto mode and tuning outputs, captures samples
  and decoded blocks from the signal path. The path itself is outside;
  inputs are synchronous to pclk.
*/
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fm_demod_rds_control #(
  parameter int CLOCK_HZ   = 50000000,
  parameter int CRYSTAL_HZ = 12288000
) (
  // apb
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // signal path in
  input  wire fm_regs_pkg::fm_sample_t     sample_in,
  input  wire fm_regs_pkg::radio_block_t   block_in,
  // controls out
  output fm_regs_pkg::fm_mode_t            mode,
  output fm_regs_pkg::fm_tuning_t          tuning,
  output logic                             path_reset,
  output logic                             radio_data_run,
  output logic                             radio_data_irq,
  output logic [15:0]                      vco_ratio_x4
);
  import fm_regs_pkg::*;

  // refused at elaboration: rates only label the build, but must make sense
  if (CLOCK_HZ < 1 || CRYSTAL_HZ < 1) begin : g_bad_rates
    $error("clock rates must be positive");
  end

  logic [15:0] control_r;
  logic [15:0] ad_cfg_r;
  logic [15:0] pll_lo_r;
  logic [PLL_HIGH_W-1:0] pll_hi_r;
  logic [15:0] ccf_lo_r;
  logic [CCF_HIGH_W-1:0] ccf_hi_r;
  logic [15:0] phscl_r;
  logic [3:0]  div_sel_r;
  logic [SAMPLE_W-1:0] left_r;
  logic [SAMPLE_W-1:0] right_r;
  logic [15:0] rds_data_r;
  logic [CHECK_W-1:0] radio_data_check_r;
  logic        irq_r;
  logic [31:0] prdata_nxt;
  logic        hit;

  function automatic logic [5:0] vco_div(input logic [1:0] sel);
    case (sel)
      2'h0:    vco_div = VCO_DIV_36;
      2'h3:    vco_div = VCO_DIV_25;
      default: vco_div = VCO_DIV_30;
    endcase
  endfunction

  function automatic logic [4:0] fm_div(input logic [1:0] sel);
    case (sel)
      2'h0:    fm_div = FM_DIV_16;
      2'h2:    fm_div = FM_DIV_20;
      default: fm_div = FM_DIV_24;
    endcase
  endfunction

  function automatic logic [31:0] byte_addr(input logic [15:0] idx);
    byte_addr = {14'h0000, idx, 2'h0};
  endfunction

  // zero-wait slave; write takes effect on the access edge
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_r <= RESET_CONTROL;
      ad_cfg_r  <= RESET_WORD;
      pll_lo_r  <= RESET_WORD;
      pll_hi_r  <= '0;
      ccf_lo_r  <= RESET_WORD;
      ccf_hi_r  <= '0;
      phscl_r   <= RESET_WORD;
      div_sel_r <= 4'h0;
    end else if (wr_en) begin
      case (paddr)
        byte_addr(IDX_FM_CONTROL):
          control_r <= merge(control_r, pwdata, pstrb) & CONTROL_WRITE_MASK;
        byte_addr(IDX_AD_FILTER_CONFIG):    ad_cfg_r <= merge(ad_cfg_r, pwdata, pstrb);
        byte_addr(IDX_PILOT_PLL_LOW):       pll_lo_r <= merge(pll_lo_r, pwdata, pstrb);
        byte_addr(IDX_PILOT_PLL_HIGH): begin
          pll_hi_r <= PLL_HIGH_W'(merge({3'h0, pll_hi_r}, pwdata, pstrb));
        end
        byte_addr(IDX_CARRIER_CENTER_LOW):  ccf_lo_r <= merge(ccf_lo_r, pwdata, pstrb);
        byte_addr(IDX_CARRIER_CENTER_HIGH): begin
          ccf_hi_r <= CCF_HIGH_W'(merge({5'h00, ccf_hi_r}, pwdata, pstrb));
        end
        // scaling register is read-only on the map but must be loadable
        byte_addr(IDX_IQ_PHASE_SCALING):    phscl_r <= merge(phscl_r, pwdata, pstrb);
        byte_addr(IDX_DIVIDER_SELECT): begin
          if (pstrb[0])
            div_sel_r <= pwdata[3:0];
        end
        default: ;
      endcase
    end
  end

  // mode decode
  always_comb begin
    mode.demod_enable         = control_r[BIT_DEMOD_ENABLE];
    mode.carrier_lock_enable  = control_r[BIT_CARRIER_LOCK];
    mode.radio_data_enable    = control_r[BIT_RADIO_DATA_EN];
    mode.deemphasis_select    = control_r[BIT_DEEMPHASIS];
    mode.mono_select          = control_r[BIT_MONO];
    mode.radio_data_hold_sync = control_r[BIT_HOLD_SYNC];
    mode.global_sync_enable   = control_r[BIT_GLOBAL_ENABLE];
    mode.iq_comp_enable       = control_r[BIT_IQ_COMP];
    mode.ext_input_sel_3      = control_r[BIT_EXT_SEL_3];
    mode.ext_input_sel_1      = control_r[BIT_EXT_SEL_1];
    mode.ext_input_sel_2      = control_r[BIT_EXT_SEL_2];
  end

  // held in reset while global enable is low; toggling it resynchronises
  assign path_reset = !control_r[BIT_GLOBAL_ENABLE];
  assign radio_data_run = control_r[BIT_RADIO_DATA_EN] && control_r[BIT_GLOBAL_ENABLE];

  always_comb begin
    tuning.pilot_pll_factor = {pll_hi_r, pll_lo_r};
    tuning.carrier_center   = {ccf_hi_r, ccf_lo_r};
    // fixed centre when lock disabled is kept by the path using this value
    tuning.i_scale_factor   = control_r[BIT_IQ_COMP] ? phscl_r[15:8] : 8'h00;
    tuning.q_scale_factor   = control_r[BIT_IQ_COMP] ? phscl_r[7:0]  : 8'h00;
    tuning.vco_divider      = vco_div(div_sel_r[1:0]);
    tuning.channel_divider  = fm_div(div_sel_r[3:2]);
    tuning.ad_filter_config = ad_cfg_r;
  end

  // integer part of 4*(4*div + 16 + ccf/2^21); ccf fraction kept to quarters
  always_comb begin
    logic signed [27:0] ccf_q;
    ccf_q = 28'(signed'({ccf_hi_r, ccf_lo_r})) >>> 19;
    vco_ratio_x4 = 16'(({10'h000, tuning.vco_divider} << 4) + 16'h0040 + 16'(ccf_q));
  end

  // samples at crystal/384 are strobed by sample_in.valid from the path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_r  <= '0;
      right_r <= '0;
    end else if (path_reset) begin
      left_r  <= '0;
      right_r <= '0;
    end else if (sample_in.valid) begin
      left_r  <= sample_in.left;
      right_r <= sample_in.right;
    end
  end

  // blocks arrive at 1187.5 bit/s from the path, no correction here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rds_data_r <= RESET_WORD;
      radio_data_check_r  <= '0;
      irq_r      <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      if (radio_data_run && block_in.valid) begin
        rds_data_r <= block_in.data_word;
        radio_data_check_r  <= {block_in.block_checkword, block_in.block_valid, block_in.block_index};
        irq_r      <= 1'b1;
      end
    end
  end
  assign radio_data_irq = irq_r;

  always_comb begin
    hit = 1'b1;
    prdata_nxt = 32'h0000_0000;
    case (paddr)
      byte_addr(IDX_FM_CONTROL):          prdata_nxt[15:0] = control_r;
      byte_addr(IDX_AD_FILTER_CONFIG):    prdata_nxt[15:0] = ad_cfg_r;
      byte_addr(IDX_PILOT_PLL_LOW):       prdata_nxt[15:0] = pll_lo_r;
      byte_addr(IDX_PILOT_PLL_HIGH):      prdata_nxt[PLL_HIGH_W-1:0] = pll_hi_r;
      byte_addr(IDX_CARRIER_CENTER_LOW):  prdata_nxt[15:0] = ccf_lo_r;
      byte_addr(IDX_CARRIER_CENTER_HIGH): prdata_nxt[CCF_HIGH_W-1:0] = ccf_hi_r;
      byte_addr(IDX_LEFT_LOW_BITS):       prdata_nxt[LSB_FIELD_POS+:2] = left_r[1:0];
      byte_addr(IDX_LEFT_HIGH_BITS):      prdata_nxt[15:0] = left_r[17:2];
      byte_addr(IDX_RIGHT_LOW_BITS):      prdata_nxt[LSB_FIELD_POS+:2] = right_r[1:0];
      byte_addr(IDX_RIGHT_HIGH_BITS):     prdata_nxt[15:0] = right_r[17:2];
      byte_addr(IDX_RADIO_DATA_WORD):     prdata_nxt[15:0] = rds_data_r;
      byte_addr(IDX_RADIO_DATA_CHECK):    prdata_nxt[CHECK_W-1:0] = radio_data_check_r;
      byte_addr(IDX_IQ_PHASE_SCALING):    prdata_nxt[15:0] = phscl_r;
      byte_addr(IDX_DIVIDER_SELECT):      prdata_nxt[3:0] = div_sel_r;
      default:                            hit = 1'b0;
    endcase
  end

  // read data registered during setup so it is from flops in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= prdata_nxt;
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule
`default_nettype wire

/* src/fm_regs_pkg.sv */
/*
  Constants, register map and carrier types for the FM demodulator and
  radio data control block.
  Assumes an APB master with 32-bit data and word-aligned register slots.
*/
package fm_regs_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_FM_CONTROL          = 16'hFE40;
  localparam logic [15:0] IDX_AD_FILTER_CONFIG    = 16'hFE41;
  localparam logic [15:0] IDX_PILOT_PLL_LOW       = 16'hFE42;
  localparam logic [15:0] IDX_PILOT_PLL_HIGH      = 16'hFE43;
  localparam logic [15:0] IDX_CARRIER_CENTER_LOW  = 16'hFE44;
  localparam logic [15:0] IDX_CARRIER_CENTER_HIGH = 16'hFE45;
  localparam logic [15:0] IDX_LEFT_LOW_BITS       = 16'hFE4E;
  localparam logic [15:0] IDX_LEFT_HIGH_BITS      = 16'hFE4F;
  localparam logic [15:0] IDX_RIGHT_LOW_BITS      = 16'hFE50;
  localparam logic [15:0] IDX_RIGHT_HIGH_BITS     = 16'hFE51;
  localparam logic [15:0] IDX_RADIO_DATA_WORD     = 16'hFE52;
  localparam logic [15:0] IDX_RADIO_DATA_CHECK    = 16'hFE53;
  localparam logic [15:0] IDX_IQ_PHASE_SCALING    = 16'hFE5B;
  // analog divider selects, no printed slot
  localparam logic [15:0] IDX_DIVIDER_SELECT      = 16'hFE5C;

  // control fields
  localparam int BIT_DEMOD_ENABLE    = 0;
  localparam int BIT_CARRIER_LOCK    = 1;
  localparam int BIT_RADIO_DATA_EN   = 2;
  localparam int BIT_DEEMPHASIS      = 3;
  localparam int BIT_MONO            = 4;
  localparam int BIT_HOLD_SYNC       = 5;
  localparam int BIT_GLOBAL_ENABLE   = 6;
  localparam int BIT_IQ_COMP         = 7;
  localparam int BIT_EXT_SEL_3       = 12;
  localparam int BIT_EXT_SEL_1       = 13;
  localparam int BIT_EXT_SEL_2       = 14;
  // reserved bits 15 and 11:8 read zero
  localparam logic [15:0] CONTROL_WRITE_MASK = 16'h70FF;

  // widths of the narrow registers
  localparam int PLL_HIGH_W   = 13;
  localparam int CCF_HIGH_W   = 11;
  localparam int CHECK_W      = 13;
  localparam int SAMPLE_W     = 18;
  localparam int CHECKWORD_W  = 10;

  // field positions inside the check register and the sample low-bit registers
  localparam int CHK_WORD_LSB  = 3;
  localparam int CHK_VALID_BIT = 2;
  localparam int LSB_FIELD_POS = 14;

  // reset values
  localparam logic [15:0] RESET_CONTROL = 16'h0000;
  localparam logic [15:0] RESET_WORD    = 16'h0000;

  // divider decodes
  localparam logic [5:0] VCO_DIV_36 = 6'h24;
  localparam logic [5:0] VCO_DIV_30 = 6'h1E;
  localparam logic [5:0] VCO_DIV_25 = 6'h19;
  localparam logic [4:0] FM_DIV_16  = 5'h10;
  localparam logic [4:0] FM_DIV_20  = 5'h14;
  localparam logic [4:0] FM_DIV_24  = 5'h18;

  // timing: crystal/384 sample rate and 1187.5 bit/s radio data rate
  localparam int SAMPLE_DIVIDE       = 384;
  localparam int RADIO_BIT_RATE_X10  = 11875;
  localparam int BLOCK_BITS          = 26;

  typedef struct packed {
    logic       ext_input_sel_2;
    logic       ext_input_sel_1;
    logic       ext_input_sel_3;
    logic       iq_comp_enable;
    logic       global_sync_enable;
    logic       radio_data_hold_sync;
    logic       mono_select;
    logic       deemphasis_select;
    logic       radio_data_enable;
    logic       carrier_lock_enable;
    logic       demod_enable;
  } fm_mode_t;

  typedef struct packed {
    logic [28:0] pilot_pll_factor;
    logic [26:0] carrier_center;
    logic [7:0]  i_scale_factor;
    logic [7:0]  q_scale_factor;
    logic [5:0]  vco_divider;
    logic [4:0]  channel_divider;
    logic [15:0] ad_filter_config;
  } fm_tuning_t;

  typedef struct packed {
    logic                   valid;
    logic [SAMPLE_W-1:0]    left;
    logic [SAMPLE_W-1:0]    right;
  } fm_sample_t;

  typedef struct packed {
    logic                   valid;
    logic [15:0]            data_word;
    logic [CHECKWORD_W-1:0] block_checkword;
    logic                   block_valid;
    logic [1:0]             block_index;
  } radio_block_t;

endpackage

/* verification/fm_ctl_sva.sv */
/* checker for the fm control block.
   sees only the top ports; bound at the foot of this file */
`timescale 1ns/1ps
`default_nettype none
module fm_ctl_sva (
  // clock, reset, apb
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  // path and controls
  input wire fm_regs_pkg::radio_block_t block_in,
  input wire fm_regs_pkg::fm_mode_t     mode,
  input wire fm_regs_pkg::fm_tuning_t   tuning,
  input wire logic                      path_reset,
  input wire logic                      radio_data_run,
  input wire logic                      radio_data_irq,
  input wire logic [15:0]               vco_ratio_x4
);
  import fm_regs_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_path_reset_follows: assert property (path_reset == !mode.global_sync_enable)
    else $error("path reset disagrees with enable");
  a_mode_only_written: assert property (!(psel && penable && pwrite) |=> $stable(mode))
    else $error("mode moved without a write");
  a_run_gate: assert property (radio_data_run == (mode.radio_data_enable && mode.global_sync_enable))
    else $error("decoder run gate wrong");
  a_block_raises_irq: assert property (block_in.valid && radio_data_run |=> radio_data_irq)
    else $error("block gave no interrupt");
  a_irq_has_cause: assert property (radio_data_irq |-> $past(block_in.valid && radio_data_run))
    else $error("interrupt without block");
  a_irq_one_cycle: assert property (radio_data_irq |=> !radio_data_irq)
    else $error("interrupt longer than a cycle");
  a_iq_scale_gate: assert property (!mode.iq_comp_enable |->
    tuning.i_scale_factor == 8'h00 && tuning.q_scale_factor == 8'h00)
    else $error("scaling active while off");
  a_vco_div_legal: assert property (tuning.vco_divider inside {6'h24, 6'h1E, 6'h19})
    else $error("vco divider out of set");
  a_fm_div_legal: assert property (tuning.channel_divider inside {5'h10, 5'h14, 5'h18})
    else $error("channel divider out of set");
  a_ratio_plain: assert property (tuning.carrier_center == 27'h0 |->
    vco_ratio_x4 == 16'(tuning.vco_divider) * 16'h0010 + 16'h0040)
    else $error("vco ratio wrong");
  c_irq: cover property (radio_data_irq);
  c_iq_on: cover property (mode.iq_comp_enable);
  c_path_release: cover property ($fell(path_reset));
endmodule
bind fm_demod_rds_control fm_ctl_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .block_in(block_in), .mode(mode), .tuning(tuning),
  .path_reset(path_reset), .radio_data_run(radio_data_run), .radio_data_irq(radio_data_irq),
  .vco_ratio_x4(vco_ratio_x4));
`default_nettype wire

/* verification/fm_front_model.sv */
/* model of the front end and sample path.
   drives one-cycle pulses right after pclk edges */
`timescale 1ns/1ps
`default_nettype none
module fm_front_model (
  // clock
  input  wire logic                  pclk,
  // path out
  output fm_regs_pkg::fm_sample_t    sample_in,
  output fm_regs_pkg::radio_block_t  block_in
);
  import fm_regs_pkg::*;
  initial begin
    sample_in = '0;
    block_in  = '0;
  end
  // lines invert after a pulse so stale data never looks valid
  task automatic send_sample(input logic [17:0] l, input logic [17:0] r);
    @(posedge pclk);
    sample_in <= {1'b1, l, r};
    @(posedge pclk);
    sample_in <= {1'b0, ~l, ~r};
  endtask
  // blocks pass unmodified, failed crc included
  task automatic send_block(input logic [28:0] b);
    @(posedge pclk);
    block_in <= {1'b1, b};
    @(posedge pclk);
    block_in <= {1'b0, ~b};
  endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
/* self-checking bench for the fm control block.
   apb master tasks, front end model, bound checker */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fm_regs_pkg::*;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0]  paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0]   pstrb = 4'hF;
  logic         pready, pslverr, path_reset, radio_data_run, radio_data_irq, err;
  logic [15:0]  vco_ratio_x4, v;
  fm_sample_t   sample_in;
  radio_block_t block_in;
  fm_mode_t     mode;
  fm_tuning_t   tuning;
  logic [28:0]  b;
  logic [17:0]  l, r;
  int           n, n_mismatch = 0, samples_checked = 0;
  always #10 pclk = ~pclk;
  fm_demod_rds_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_in(sample_in), .block_in(block_in),
    .mode(mode), .tuning(tuning), .path_reset(path_reset), .radio_data_run(radio_data_run),
    .radio_data_irq(radio_data_irq), .vco_ratio_x4(vco_ratio_x4));
  fm_front_model u_front (.pclk(pclk), .sample_in(sample_in), .block_in(block_in));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // entered just after an edge; waits on pready with a bound
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {14'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("pready", 0, 1);
      finish_test;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rdc(input string nm, input logic [15:0] i, input logic [31:0] exp);
    apb(1'b0, i, 32'h0);
    chk(nm, rd, exp);
  endtask
  function automatic logic [5:0] vdiv(input logic [1:0] s);
    return s == 2'b00 ? 6'h24 : (s == 2'b11 ? 6'h19 : 6'h1E);
  endfunction
  function automatic logic [4:0] cdiv(input logic [1:0] s);
    return s == 2'b00 ? 5'h10 : (s == 2'b10 ? 5'h14 : 5'h18);
  endfunction
  initial begin
    void'($urandom(26360));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("path_reset", path_reset, 1);
    // every slot reads zero; holes between slots must error
    for (int k = 0; k < 29; k++) begin
      rdc("reset_val", 16'hFE40 + 16'(k), 0);
      chk("slverr", err, !(k < 6 || (k > 13 && k < 20) || k > 26));
    end
    $display("test reset done");
    for (int k = 0; k < 10; k++) begin
      v = k == 0 ? 16'hFFFF : 16'($urandom);
      wr(16'hFE40, v);
      chk("mode", mode, {v[14:12], v[7:0]});
      chk("run", radio_data_run, v[2] & v[6]);
      chk("path_reset", path_reset, !v[6]);
      rdc("control", 16'hFE40, v & 16'h70FF);
    end
    $display("test control done");
    for (int k = 0; k < 16; k++) begin
      wr(16'hFE5C, k);
      chk("vco_div", tuning.vco_divider, vdiv(k[1:0]));
      chk("fm_div", tuning.channel_divider, cdiv(k[3:2]));
      chk("ratio", vco_ratio_x4, 16'(vdiv(k[1:0])) * 16 + 64);
    end
    $display("test dividers done");
    wr(16'hFE45, 16'hFF87);
    wr(16'hFE44, 16'hFFFF);
    wr(16'hFE40, 16'h0041);
    chk("ccf", tuning.carrier_center, 27'h787FFFF);
    rdc("ccf_hi", 16'hFE45, 32'h787);
    chk("ratio_ccf", vco_ratio_x4, 16'h01C0);
    wr(16'hFE42, 16'hAAAA);
    wr(16'hFE43, 16'hFFFF);
    rdc("pll_hi", 16'hFE43, 32'h1FFF);
    wr(16'hFE43, 16'h032A);
    chk("pll", tuning.pilot_pll_factor, 29'h032AAAAA);
    wr(16'hFE41, 16'h0004);
    chk("ad_cfg", tuning.ad_filter_config, 16'h0004);
    wr(16'hFE5B, 16'h6F89);
    chk("iq_off", {tuning.i_scale_factor, tuning.q_scale_factor}, 0);
    wr(16'hFE40, 16'h00C1);
    chk("iq_on", {tuning.i_scale_factor, tuning.q_scale_factor}, 32'h6F89);
    $display("test tuning done");
    repeat (4) begin
      l = 18'($urandom);
      r = 18'($urandom);
      u_front.send_sample(l, r);
      rdc("left_hi", 16'hFE4F, l[17:2]);
      rdc("left_lo", 16'hFE4E, {l[1:0], 14'h0});
      rdc("right_hi", 16'hFE51, r[17:2]);
      rdc("right_lo", 16'hFE50, {r[1:0], 14'h0});
    end
    wr(16'hFE40, 16'h0081);
    rdc("cleared", 16'hFE4F, 0);
    $display("test samples done");
    wr(16'hFE40, 16'h0045);
    for (int k = 0; k < 4; k++) begin
      b = {16'($urandom), 10'($urandom), 1'(k), 2'(k)};
      u_front.send_block(b);
      n = 0;
      while (radio_data_irq !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n++;
      end
      chk("irq_lat", n, 1);
      @(posedge pclk);
      chk("irq_pulse", radio_data_irq, 0);
      rdc("data", 16'hFE52, b[28:13]);
      rdc("check", 16'hFE53, b[12:0]);
    end
    wr(16'hFE40, 16'h0041);
    u_front.send_block(~b);
    repeat (3) begin
      @(posedge pclk);
      chk("irq_off", radio_data_irq, 0);
    end
    rdc("data_kept", 16'hFE52, b[28:13]);
    $display("test blocks done");
    finish_test;
  end
endmodule
`default_nettype wire
